// *** src/coupler_pkg.sv ***
// Purpose: shared constants for the coupler glue logic
// Assumes: 125 MHz system clock
// Notes: memory map and pulse timing live here
package coupler_pkg;
   // ----------------------------------------
   // memory map
   // ----------------------------------------
   localparam logic [15:0] PROG_BASE = 16'h0000; // program memory, 32 kbyte
   localparam logic [15:0] PROG_SIZE_M1 = 16'h7FFF;
   localparam logic [15:0] RAM_BASE = 16'h8000; // data ram, 8 kbyte
   localparam logic [15:0] RAM_SIZE_M1 = 16'h1FFF;
   localparam logic [15:0] FREQ_ADDR = 16'hA000; // frequency byte read port
   localparam logic [15:0] WDOG_ADDR = 16'hA001; // watchdog clear by write
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int PULSE_US = 10; // relay pulse width in microseconds
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int WDOG_COUNT = 1024; // frequency clock edges before expiry
   // ----------------------------------------
   // relay pulse states
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      P_IDLE = 2'b00,
      P_COIL_A = 2'b01,
      P_COIL_B = 2'b10
   } pulse_state_t;
endpackage

// *** src/relay_if.sv ***
// Purpose: request and pulse bundle between top and relay driver
// Assumes: single clock
// Notes: one instance per latching relay
`timescale 1ns/10ps
interface relay_if;
   logic req_a; // request coil a pulse
   logic req_b; // request coil b pulse
   logic coil_a; // coil a drive, active high
   logic coil_b; // coil b drive, active high
   logic busy; // pulse in progress
   modport ctrl (output req_a, output req_b, input coil_a, input coil_b, input busy);
   modport drv (input req_a, input req_b, output coil_a, output coil_b, output busy);
endinterface

// *** src/relay_pulser.sv ***
// Purpose: one latching relay coil pulse generator
// Assumes: requests are one-cycle or level, taken only when idle
// Notes: coil a wins if both requested together
`timescale 1ns/10ps
module relay_pulser
   import coupler_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC
)
(
   input wire logic clk, // system clock
   input wire logic rstn, // sync reset, active low
   input wire logic ce, // clock enable
   relay_if.drv rif // request and coil bundle
);
   initial
   begin
      if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535)
         $error("pulse width out of range");
   end
   pulse_state_t state_reg; // current coil
   logic [15:0] cnt_reg; // cycles left in pulse
   // ----------------------------------------
   // pulse sequencer
   // ----------------------------------------
   // requests during a pulse are dropped so both coils never overlap
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_reg <= P_IDLE;
         cnt_reg <= 16'h0000;
      end
      else if (ce)
      begin
         case (state_reg)
            P_IDLE:
            begin
               if (rif.req_a) // see [RULE22]
               begin
                  state_reg <= P_COIL_A;
                  cnt_reg <= 16'(PULSE_CYCLES - 1);
               end
               else if (rif.req_b)
               begin
                  state_reg <= P_COIL_B;
                  cnt_reg <= 16'(PULSE_CYCLES - 1);
               end
            end
            P_COIL_A, P_COIL_B:
            begin
               if (cnt_reg == 16'h0000)
                  state_reg <= P_IDLE;
               else
                  cnt_reg <= cnt_reg - 16'h0001;
            end
            default:
               state_reg <= P_IDLE;
         endcase
      end
   end
   // coils decoded from one state, hence mutually exclusive
   assign rif.coil_a = (state_reg == P_COIL_A); // see [RULE3]
   assign rif.coil_b = (state_reg == P_COIL_B); // see [RULE22]
   assign rif.busy = (state_reg != P_IDLE);
   no_overlap_a: assert property (@(posedge clk) disable iff (!rstn)
      !(rif.coil_a && rif.coil_b)) else $error("both coils driven"); // see [RULE22]
endmodule

// *** src/coupler_glue.sv ***
// Purpose: glue logic around the coupler microcontroller
// Assumes: bus strobes, talk key and frequency bus arrive asynchronously
// Notes: relay outputs are pulses, coil switches are levels
`timescale 1ns/10ps
// How it works
// [RULE1] whip select: one low pulse, then high
// [RULE2] dipole select: one low pulse, then high
// [RULE3] select lines idle inactive between commands
// [RULE4] coil bypass set: one positive pulse
// [RULE5] coil bypass clear: one positive pulse
// [RULE6] shunt cap connect/disconnect positive pulses
// [RULE7] coil switches are levels, high bypasses
// [RULE8] latch low address, join high byte
// [RULE9] capture on falling address strobe
// [RULE10] controller drives low and high address bytes
// [RULE11] decode address with strobes to selects
// [RULE12] program region up to 32 kbyte
// [RULE13] data ram region up to 8 kbyte
// [RULE14] interrupt on every talk key change
// [RULE15] deserialize frequency bytes, interrupt each byte
// [RULE16] watchdog counts frequency clocks, resets processor
// [RULE17] remote may expire watchdog deliberately
// [RULE18] all logic on one system clock
// [RULE19] read strobe low throughout reads
// [RULE20] write strobe low throughout writes
// [RULE21] watchdog count and pulse width parameters
// [RULE22] no overlapping coils, requests after pulse
module coupler_glue
   import coupler_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC, // see [RULE21]
   parameter int WDOG_LIMIT = WDOG_COUNT, // see [RULE21]
   parameter int NSW = 12 // static coil switch count
)
(
   input wire logic clk, // system clock, see [RULE18]
   input wire logic rstn, // sync reset, active low
   input wire logic ce, // clock enable
   input wire logic ale, // address latch strobe pin
   input wire logic rd_n, // read strobe pin, active low
   input wire logic wr_n, // write strobe pin, active low
   input wire logic [7:0] muxed_addr_data_bus, // shared low address and data
   input wire logic [7:0] high_address_lines, // high address byte
   output logic [7:0] bus_rd_data, // read data toward processor
   output logic bus_rd_oe, // high while driving data lines
   output logic [15:0] full_addr, // latched 16-bit address
   output logic prog_cs_n, // program memory select
   output logic ram_cs_n, // data ram select
   output logic freq_cs_n, // frequency port select
   input wire logic talk_key_line, // talk key from radio
   output logic talk_irq_n, // talk key change interrupt
   input wire logic freq_clk, // frequency bus clock pin
   input wire logic freq_data, // frequency bus data pin
   output logic freq_irq_n, // new byte interrupt
   output logic cpu_reset, // watchdog reset to processor
   input wire logic irq_ack, // processor clears both interrupts
   input wire logic whip_req, // select whip path
   input wire logic dipole_req, // select dipole path
   input wire logic coil1_bypass_req, // bypass first coil
   input wire logic coil1_insert_req, // insert first coil
   input wire logic cap_on_req, // connect shunt cap
   input wire logic cap_off_req, // disconnect shunt cap
   input wire logic [NSW-1:0] sw_bypass, // static switch settings
   output logic whip_sel_n, // antenna_select_relay whip coil
   output logic dipole_sel_n, // antenna_select_relay dipole coil
   output logic coil1_bypass_set_pulse, // coil1_bypass_relay set
   output logic coil1_bypass_clear_pulse, // coil1_bypass_relay reset
   output logic shunt_cap_connect_pulse, // shunt_cap_relay set
   output logic shunt_cap_disconnect_pulse, // shunt_cap_relay reset
   output logic [NSW-1:0] sw_level // coil switch levels
);
   initial
   begin
      if (WDOG_LIMIT < 2 || WDOG_LIMIT > 65535)
         $error("watchdog limit out of range");
      if (NSW < 1)
         $error("switch count out of range");
   end
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [5:0] sync1_reg; // first stage, read only by stage two
   logic [5:0] sync2_reg; // second stage
   logic [5:0] last_reg; // previous synced value, for edges
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         // strobe idles low, the rest idle high: no false edge after reset
         sync1_reg <= 6'h1F;
         sync2_reg <= 6'h1F;
         last_reg <= 6'h1F;
      end
      else if (ce)
      begin
         sync1_reg <= {ale, rd_n, wr_n, talk_key_line, freq_clk, freq_data};
         sync2_reg <= sync1_reg;
         last_reg <= sync2_reg;
      end
   end
   logic ale_fall; // address strobe falling edge
   logic rd_s; // read active, synced
   logic wr_fall; // write strobe start
   logic talk_chg; // talk key changed
   logic fclk_rise; // frequency clock rising edge
   assign ale_fall = last_reg[5] && !sync2_reg[5];
   assign rd_s = !sync2_reg[4];
   assign wr_fall = last_reg[3] && !sync2_reg[3];
   assign talk_chg = last_reg[2] != sync2_reg[2];
   assign fclk_rise = !last_reg[1] && sync2_reg[1];
   // ----------------------------------------
   // address latch
   // ----------------------------------------
   // address pins get two flops as well, so they line up with the synced strobe
   logic [15:0] addr_s1_reg; // first stage, read only by stage two
   logic [15:0] addr_s2_reg; // second stage
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         addr_s1_reg <= 16'h0000;
         addr_s2_reg <= 16'h0000;
      end
      else if (ce)
      begin
         addr_s1_reg <= {high_address_lines, muxed_addr_data_bus};
         addr_s2_reg <= addr_s1_reg;
      end
   end
   // limitation: the controller must hold the low byte a few cycles past the fall
   always_ff @(posedge clk)
   begin
      if (!rstn)
         full_addr <= 16'h0000;
      else if (ce && ale_fall) // see [RULE9]
         full_addr <= addr_s2_reg; // see [RULE8]
   end
   // ----------------------------------------
   // decoder
   // ----------------------------------------
   logic in_prog; // address in program region
   logic in_ram; // address in ram region
   assign in_prog = (full_addr & ~PROG_SIZE_M1) == PROG_BASE; // see [RULE12]
   assign in_ram = (full_addr & ~RAM_SIZE_M1) == RAM_BASE; // see [RULE13]
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         prog_cs_n <= 1'b1;
         ram_cs_n <= 1'b1;
         freq_cs_n <= 1'b1;
      end
      else if (ce)
      begin
         // strobes gate the selects so idle bus cycles select nothing
         prog_cs_n <= !(in_prog && rd_s); // see [RULE11]
         ram_cs_n <= !(in_ram && (rd_s || !sync2_reg[3])); // see [RULE11]
         freq_cs_n <= !(full_addr == FREQ_ADDR && rd_s); // see [RULE19]
      end
   end
   // ----------------------------------------
   // frequency bus reader
   // ----------------------------------------
   logic [7:0] shift_reg; // incoming bits, msb first
   logic [2:0] bit_reg; // bits collected
   logic [7:0] fbyte_reg; // last completed byte
   logic byte_done; // byte completes this cycle
   assign byte_done = fclk_rise && bit_reg == 3'h7;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         shift_reg <= 8'h00;
         bit_reg <= 3'h0;
         fbyte_reg <= 8'h00;
      end
      else if (ce && fclk_rise)
      begin
         shift_reg <= {shift_reg[6:0], sync2_reg[0]}; // see [RULE15]
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == 3'h7)
            fbyte_reg <= {shift_reg[6:0], sync2_reg[0]};
      end
   end
   // read data driven only while read strobe low and port selected
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         bus_rd_data <= 8'h00;
         bus_rd_oe <= 1'b0;
      end
      else if (ce)
      begin
         bus_rd_data <= fbyte_reg; // see [RULE15]
         bus_rd_oe <= rd_s && full_addr == FREQ_ADDR; // see [RULE19]
      end
   end
   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   // set wins over ack so an edge in the ack cycle is kept
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         talk_irq_n <= 1'b1;
         freq_irq_n <= 1'b1;
      end
      else if (ce)
      begin
         if (talk_chg) // see [RULE14]
            talk_irq_n <= 1'b0;
         else if (irq_ack)
            talk_irq_n <= 1'b1;
         if (byte_done) // see [RULE15]
            freq_irq_n <= 1'b0;
         else if (irq_ack)
            freq_irq_n <= 1'b1;
      end
   end
   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   logic [15:0] wd_reg; // frequency clocks since clear
   logic wd_clr; // software clear by write
   assign wd_clr = wr_fall && full_addr == WDOG_ADDR;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wd_reg <= 16'h0000;
         cpu_reset <= 1'b0;
      end
      else if (ce)
      begin
         // remote side may run clocks on purpose to force expiry
         if (wd_clr) // see [RULE17]
         begin
            wd_reg <= 16'h0000;
            cpu_reset <= 1'b0;
         end
         else if (fclk_rise && wd_reg != 16'(WDOG_LIMIT))
            wd_reg <= wd_reg + 16'h0001; // see [RULE16]
         else if (wd_reg == 16'(WDOG_LIMIT))
            cpu_reset <= 1'b1; // see [RULE16]
      end
   end
   // ----------------------------------------
   // relays
   // ----------------------------------------
   relay_if ant_if();
   relay_if coil_if();
   relay_if cap_if();
   assign ant_if.req_a = whip_req; // see [RULE1]
   assign ant_if.req_b = dipole_req; // see [RULE2]
   assign coil_if.req_a = coil1_bypass_req; // see [RULE4]
   assign coil_if.req_b = coil1_insert_req; // see [RULE5]
   assign cap_if.req_a = cap_on_req; // see [RULE6]
   assign cap_if.req_b = cap_off_req; // see [RULE6]
   relay_pulser #(.PULSE_CYCLES(PULSE_CYCLES)) ant_u (.clk(clk), .rstn(rstn), .ce(ce),
      .rif(ant_if));
   relay_pulser #(.PULSE_CYCLES(PULSE_CYCLES)) coil_u (.clk(clk), .rstn(rstn), .ce(ce),
      .rif(coil_if));
   relay_pulser #(.PULSE_CYCLES(PULSE_CYCLES)) cap_u (.clk(clk), .rstn(rstn), .ce(ce),
      .rif(cap_if));
   // registered outputs; selects idle high between pulses
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         whip_sel_n <= 1'b1;
         dipole_sel_n <= 1'b1;
         coil1_bypass_set_pulse <= 1'b0;
         coil1_bypass_clear_pulse <= 1'b0;
         shunt_cap_connect_pulse <= 1'b0;
         shunt_cap_disconnect_pulse <= 1'b0;
      end
      else if (ce)
      begin
         whip_sel_n <= !ant_if.coil_a; // see [RULE1]
         dipole_sel_n <= !ant_if.coil_b; // see [RULE3]
         coil1_bypass_set_pulse <= coil_if.coil_a; // see [RULE4]
         coil1_bypass_clear_pulse <= coil_if.coil_b; // see [RULE5]
         shunt_cap_connect_pulse <= cap_if.coil_a; // see [RULE6]
         shunt_cap_disconnect_pulse <= cap_if.coil_b; // see [RULE6]
      end
   end
   // static switches, one flop per bit
   genvar gi;
   generate
      for (gi = 0; gi < NSW; gi++)
      begin : g_sw
         always_ff @(posedge clk)
         begin
            if (!rstn)
               sw_level[gi] <= 1'b0;
            else if (ce)
               sw_level[gi] <= sw_bypass[gi]; // see [RULE7]
         end
      end
   endgenerate
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sel_excl_a: assert property (@(posedge clk) disable iff (!rstn)
      !(!whip_sel_n && !dipole_sel_n)) else $error("both selects low"); // see [RULE3]
   talk_irq_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && talk_chg) |=> !talk_irq_n) else $error("talk irq missed"); // see [RULE14]
   freq_irq_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && byte_done) |=> !freq_irq_n) else $error("byte irq missed"); // see [RULE15]
   addr_latch_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && ale_fall) |=> full_addr == $past(addr_s2_reg))
      else $error("low address not latched"); // see [RULE8]
   wd_fire_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && wd_reg == 16'(WDOG_LIMIT) && !wd_clr) |=> cpu_reset)
      else $error("watchdog did not fire"); // see [RULE16]
   cap_excl_a: assert property (@(posedge clk) disable iff (!rstn)
      !(shunt_cap_connect_pulse && shunt_cap_disconnect_pulse))
      else $error("cap coils overlap"); // see [RULE22]
   coil_excl_a: assert property (@(posedge clk) disable iff (!rstn)
      !(coil1_bypass_set_pulse && coil1_bypass_clear_pulse))
      else $error("coil relay overlap"); // see [RULE22]
   whip_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && ant_if.coil_a) |=> !whip_sel_n) else $error("whip pulse missing"); // see [RULE1]
   whip_c: cover property (@(posedge clk) $fell(whip_sel_n));
   reset_c: cover property (@(posedge clk) $rose(cpu_reset));
   byte_c: cover property (@(posedge clk) $fell(freq_irq_n));
endmodule

// *** verif/cpu_bus_model.sv ***
// Purpose: processor side of the multiplexed address and data bus
// Assumes: every strobe moves just after a rising clock edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
module cpu_bus_model
(
   input wire logic clk, // system clock
   output logic ale, // address latch strobe
   output logic rd_n, // read strobe, active low
   output logic wr_n, // write strobe, active low
   output logic [7:0] ad, // shared low address and data lines
   output logic [7:0] hi // high address lines
);
   // ------------------------------------------------
   // idle bus
   // ------------------------------------------------
   initial
   begin
      ale = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ad = 8'hFF;
      hi = 8'h00;
   end
   // ------------------------------------------------
   // bus phases
   // ------------------------------------------------
   // wrong low byte first, so a capture on the rising strobe shows up
   task automatic addr_phase(input logic [15:0] a);
      @(posedge clk) #1;
      hi = a[15:8];
      ad = ~a[7:0];
      ale = 1'b1;
      repeat (5) @(posedge clk) #1;
      ad = a[7:0];
      repeat (4) @(posedge clk) #1;
      ale = 1'b0;
      repeat (5) @(posedge clk) #1; // low byte held past the synced capture
   endtask
   // strobe stays low for the whole transfer
   task automatic strobe(input logic wr, input logic [7:0] d);
      if (wr)
      begin
         ad = d;
         wr_n = 1'b0;
      end
      else
      begin
         ad = ~ad; // released, device drives the read data
         rd_n = 1'b0;
      end
      repeat (6) @(posedge clk) #1;
   endtask
   task automatic end_cycle();
      rd_n = 1'b1;
      wr_n = 1'b1;
      ad = ~ad;
      repeat (5) @(posedge clk) #1;
   endtask
endmodule

// *** verif/coupler_glue_bench.sv ***
// Purpose: self-checking bench for the coupler glue logic
// Assumes: 125 MHz clock, shortened pulse width and watchdog limit
// Notes: relay pulses are checked against a queue of expected notes
`timescale 1ns/10ps
module coupler_glue_bench
   import coupler_pkg::*;
();
   localparam int P = 4; // short relay pulse
   localparam int WD = 12; // short watchdog limit
   logic clk, rstn, ce, ale, rd_n, wr_n, talk_key_line, freq_clk, freq_data, irq_ack;
   logic [7:0] ad, hi, bus_rd_data, b;
   logic bus_rd_oe, prog_cs_n, ram_cs_n, freq_cs_n, talk_irq_n, freq_irq_n, cpu_reset;
   logic [15:0] full_addr;
   logic [5:0] req, act; // relay requests and active coils, same order
   logic [11:0] sw_bypass, sw_level;
   logic whip_sel_n, dipole_sel_n, set_p, clr_p, con_p, dis_p;
   logic [15:0] at [8] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hA001,
      16'hA002, 16'hFFFF}; // map boundaries and unmapped places
   int q[$]; // expected pulses, line * 1000 + width
   int cnt [6];
   int e, checks, mismatches;
   integer seed = 32'hFE947458;
   // ------------------------------------------------
   // clock, partner and design
   // ------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   cpu_bus_model cpu (.clk(clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad(ad), .hi(hi));
   coupler_glue #(.PULSE_CYCLES(P), .WDOG_LIMIT(WD)) DUT (.clk(clk), .rstn(rstn), .ce(ce),
      .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .muxed_addr_data_bus(ad), .high_address_lines(hi),
      .bus_rd_data(bus_rd_data), .bus_rd_oe(bus_rd_oe), .full_addr(full_addr),
      .prog_cs_n(prog_cs_n), .ram_cs_n(ram_cs_n), .freq_cs_n(freq_cs_n),
      .talk_key_line(talk_key_line), .talk_irq_n(talk_irq_n), .freq_clk(freq_clk),
      .freq_data(freq_data), .freq_irq_n(freq_irq_n), .cpu_reset(cpu_reset),
      .irq_ack(irq_ack), .whip_req(req[0]), .dipole_req(req[1]), .coil1_bypass_req(req[2]),
      .coil1_insert_req(req[3]), .cap_on_req(req[4]), .cap_off_req(req[5]),
      .sw_bypass(sw_bypass), .whip_sel_n(whip_sel_n), .dipole_sel_n(dipole_sel_n),
      .coil1_bypass_set_pulse(set_p), .coil1_bypass_clear_pulse(clr_p),
      .shunt_cap_connect_pulse(con_p), .shunt_cap_disconnect_pulse(dis_p), .sw_level(sw_level));
   assign act = {dis_p, con_p, clr_p, set_p, ~dipole_sel_n, ~whip_sel_n};
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk) #1;
   endtask
   // one-cycle request; a refused one leaves no note
   task automatic relay(input int i, input bit expect_pulse);
      req[i] = 1'b1;
      if (expect_pulse)
         q.push_back(i * 1000 + P);
      step(1);
      req[i] = 1'b0;
   endtask
   task automatic bus_cycle(input logic [15:0] a, input logic wr, input logic [7:0] d);
      logic rd;
      rd = !wr;
      cpu.addr_phase(a);
      check("full_addr", full_addr, a);
      cpu.strobe(wr, d);
      check("prog_cs_n", prog_cs_n, !(rd && a <= PROG_SIZE_M1));
      check("ram_cs_n", ram_cs_n, !(a >= RAM_BASE && a <= RAM_BASE + RAM_SIZE_M1));
      check("freq_cs_n", freq_cs_n, !(rd && a == FREQ_ADDR));
      check("bus_rd_oe", bus_rd_oe, rd && a == FREQ_ADDR);
      if (rd && a == FREQ_ADDR)
         check("bus_rd_data", bus_rd_data, b);
      cpu.end_cycle();
   endtask
   // frequency clock idles high, data set before each rise, MSB first
   task automatic send_bits(input logic [7:0] v, input int n);
      for (int k = 0; k < n; k++)
      begin
         freq_data = v[7 - k];
         freq_clk = 1'b0;
         step(3);
         freq_clk = 1'b1;
         step(3);
      end
      freq_data = ~freq_data; // no stale level between frames
   endtask
   task automatic wait_irq(input bit talk);
      int n;
      n = 0;
      while ((talk ? talk_irq_n : freq_irq_n) !== 1'b0 && n < 20)
      begin
         step(1);
         n++;
      end
      check("irq low", talk ? talk_irq_n : freq_irq_n, 0);
      irq_ack = 1'b1;
      step(1);
      irq_ack = 1'b0;
      step(2);
      check("irq cleared", talk ? talk_irq_n : freq_irq_n, 1);
   endtask
   // ------------------------------------------------
   // relay pulse monitor, oldest note per finished pulse
   // ------------------------------------------------
   always @(negedge clk)
   begin
      if (|act)
         check("coil overlap", {act[0] & act[1], act[2] & act[3], act[4] & act[5]}, 0);
      for (int i = 0; i < 6; i++)
         if (act[i] === 1'b1)
            cnt[i]++;
         else if (cnt[i] > 0)
         begin
            e = (q.size() > 0) ? q.pop_front() : -1; // stray pulse never matches
            check("pulse", i * 1000 + cnt[i], e);
            cnt[i] = 0;
         end
   end
   // ------------------------------------------------
   // watchdog on the run itself
   // ------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim();
   end
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      {rstn, irq_ack, req, sw_bypass} = '0;
      {talk_key_line, freq_clk, freq_data, ce} = 4'b1111; // idle high, no false edges
      b = 8'h00;
      step(5);
      rstn = 1'b1;
      step(2);
      check("idle", {whip_sel_n, dipole_sel_n, talk_irq_n, cpu_reset}, 4'hE);
      for (int i = 0; i < 6; i++)
      begin
         relay(i, 1);
         step(P + 3);
      end
      relay(0, 1);
      step(2);
      relay(1, 0); // same relay still busy, refused
      step(P + 4);
      req = 6'b010100; // two relays at once are independent
      q.push_back(2000 + P);
      q.push_back(4000 + P);
      step(1);
      req = '0;
      step(P + 4);
      $display("test relays done");
      repeat (4)
      begin
         sw_bypass = 12'($random(seed));
         step(2);
         check("sw_level", sw_level, sw_bypass);
      end
      ce = 1'b0; // frozen: levels must not follow
      sw_bypass = ~sw_level;
      step(3);
      check("sw_level held", sw_level ^ sw_bypass, 12'hFFF);
      ce = 1'b1;
      step(2);
      check("sw_level", sw_level, sw_bypass);
      $display("test switches done");
      talk_key_line = 1'b0;
      wait_irq(1);
      talk_key_line = 1'b1;
      wait_irq(1);
      $display("test talk key done");
      repeat (2)
      begin
         b = 8'($random(seed));
         send_bits(b, 8);
         wait_irq(0);
         bus_cycle(FREQ_ADDR, 1'b0, 8'h00);
         bus_cycle(WDOG_ADDR, 1'b1, 8'($random(seed)));
      end
      $display("test frequency bytes done");
      for (int k = 0; k < 8; k++)
         for (int w = 0; w < 2; w++)
            bus_cycle(at[k], w[0], 8'($random(seed)));
      $display("test decoder done");
      bus_cycle(WDOG_ADDR, 1'b1, 8'h00);
      send_bits(8'hA5, 8);
      send_bits(8'h5A, WD - 9);
      step(4);
      check("cpu_reset", cpu_reset, 0);
      send_bits(8'h3C, 1);
      step(4);
      check("cpu_reset", cpu_reset, 1);
      bus_cycle(WDOG_ADDR, 1'b1, 8'h00);
      check("cpu_reset", cpu_reset, 0);
      $display("test watchdog done");
      check("notes left", q.size(), 0);
      end_sim();
   end
endmodule
